// *** pkg/lbx_defines.vh ***
// Constants shared by the logic and branch execution block
`ifndef LBX_DEFINES_VH
`define LBX_DEFINES_VH
// ==========================================
// Opcode patterns and field positions
`define LBX_AND_OPC 6'h05
`define LBX_AND_OPC_HI 15
`define LBX_AND_OPC_LO 10
`define LBX_TOG_OPC 4'h7
`define LBX_TOG_OPC_HI 15
`define LBX_TOG_OPC_LO 12
`define LBX_BC_OPC 8'he2
`define LBX_BOV_OPC 8'he4
`define LBX_BR_OPC_HI 15
`define LBX_BR_OPC_LO 8
`define LBX_D_BIT 9
`define LBX_A_BIT 8
`define LBX_BIT_HI 11
`define LBX_BIT_LO 9
`define LBX_F_HI 7
`define LBX_F_LO 0
`define LBX_N_HI 7
`define LBX_N_LO 0
// ==========================================
// Quarter phases and timing counts
`define LBX_Q1 2'h0
`define LBX_Q2 2'h1
`define LBX_Q3 2'h2
`define LBX_Q4 2'h3
`define LBX_Q_STEP 2'h1
`define LBX_PC_STEP 2
// ==========================================
// Access bank and reset values
`define LBX_ACC_SPLIT 8'h80
`define LBX_ACC_LO_BANK 4'h0
`define LBX_ACC_HI_BANK 4'hf
`define LBX_NOP_WORD 16'h0000
`define LBX_PC_RESET 0
`define LBX_BYTE_RESET 8'h00
`define LBX_ADDR_RESET 12'h000
`endif

// *** logic/lbx_decode.v ***
// Instruction word field decoder
`default_nettype none
module lbx_decode (
  input wire [15:0] instr_word,
  output wire is_and,
  output wire is_tog,
  output wire is_bc,
  output wire is_bov,
  output wire dest_file,
  output wire use_bank_reg,
  output wire [7:0] file_off,
  output wire [2:0] bit_num,
  output wire [7:0] br_offset
);
`include "lbx_defines.vh"
  // ==========================================
  // Opcode match
  assign is_and = instr_word[`LBX_AND_OPC_HI:`LBX_AND_OPC_LO] == `LBX_AND_OPC;
  assign is_tog = instr_word[`LBX_TOG_OPC_HI:`LBX_TOG_OPC_LO] == `LBX_TOG_OPC;
  assign is_bc = instr_word[`LBX_BR_OPC_HI:`LBX_BR_OPC_LO] == `LBX_BC_OPC;
  assign is_bov = instr_word[`LBX_BR_OPC_HI:`LBX_BR_OPC_LO] == `LBX_BOV_OPC;
  // ==========================================
  // Operand fields
  assign dest_file = instr_word[`LBX_D_BIT];
  assign use_bank_reg = instr_word[`LBX_A_BIT];
  assign file_off = instr_word[`LBX_F_HI:`LBX_F_LO];
  assign bit_num = instr_word[`LBX_BIT_HI:`LBX_BIT_LO];
  assign br_offset = instr_word[`LBX_N_HI:`LBX_N_LO];
endmodule // lbx_decode
`default_nettype wire

// *** logic/lbx_branch.v ***
// Shared relative branch datapath
`default_nettype none
module lbx_branch #(
  parameter PCW = 21
) (
  input wire [PCW-1:0] pc_cur,
  input wire [7:0] offset,
  input wire sel_ovf,
  input wire carry_flag,
  input wire overflow_flag,
  output wire taken,
  output wire [PCW-1:0] target
);
`include "lbx_defines.vh"
  localparam [31:0] PC_STEP_W = `LBX_PC_STEP;
  localparam [PCW-1:0] PC_STEP = PC_STEP_W[PCW-1:0];
  wire [PCW-1:0] off2_ext;
  wire [PCW-1:0] pc_inc;
  // ==========================================
  // Target and condition
  assign off2_ext = {{(PCW-9){offset[7]}}, offset, 1'b0};
  assign pc_inc = pc_cur + PC_STEP;
  assign target = pc_inc + off2_ext;
  assign taken = sel_ovf ? overflow_flag : carry_flag;
endmodule // lbx_branch
`default_nettype wire

// *** logic/lbx_exec.v ***
// Execution unit for AND with file, bit toggle and carry/overflow branches
`default_nettype none
module lbx_exec #(
  parameter PCW = 21
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  input wire [15:0] instr_word,
  input wire [7:0] wreg_value,
  input wire [3:0] bank_select_reg,
  input wire carry_flag,
  input wire overflow_flag,
  input wire [7:0] file_rd_data,
  output wire [1:0] quarter,
  output wire [PCW-1:0] program_counter,
  output wire [11:0] file_addr,
  output wire file_rd_en,
  output wire file_wr_en,
  output wire [7:0] file_wr_data,
  output wire wreg_wr_en,
  output wire [7:0] wreg_wr_data,
  output wire flag_wr_en,
  output wire neg_flag,
  output wire zero_flag,
  output wire pc_wr_en,
  output wire nop_cycle
);
`include "lbx_defines.vh"
  localparam [31:0] PC_STEP_W = `LBX_PC_STEP;
  localparam [31:0] PC_RESET_W = `LBX_PC_RESET;
  localparam [PCW-1:0] PC_STEP = PC_STEP_W[PCW-1:0];
  localparam [PCW-1:0] PC_RESET = PC_RESET_W[PCW-1:0];

  // ==========================================
  // State
  reg [1:0] q_q;
  reg [1:0] q_d;
  reg [15:0] ir_q;
  reg [15:0] ir_d;
  reg flush_q;
  reg flush_d;
  reg [PCW-1:0] pc_q;
  reg [PCW-1:0] pc_d;
  reg [PCW-1:0] target_q;
  reg [PCW-1:0] target_d;
  reg taken_q;
  reg taken_d;
  reg [7:0] opnd_q;
  reg [7:0] opnd_d;
  reg [11:0] faddr_q;
  reg [11:0] faddr_d;
  reg frd_q;
  reg frd_d;
  reg fwr_q;
  reg fwr_d;
  reg [7:0] fdat_q;
  reg [7:0] fdat_d;
  reg wwr_q;
  reg wwr_d;
  reg [7:0] wdat_q;
  reg [7:0] wdat_d;
  reg flg_q;
  reg flg_d;
  reg neg_q;
  reg neg_d;
  reg zero_q;
  reg zero_d;
  reg pcw_q;
  reg pcw_d;

  // ==========================================
  // Decoders for incoming and held words
  wire nw_and;
  wire nw_tog;
  wire nw_bank;
  wire [7:0] nw_off;
  wire cu_and;
  wire cu_tog;
  wire cu_bc;
  wire cu_bov;
  wire cu_dest;
  wire [2:0] cu_bit;
  wire [7:0] cu_boff;

  lbx_decode u_dec_new (
    .instr_word(ir_d),
    .is_and(nw_and),
    .is_tog(nw_tog),
    .is_bc(),
    .is_bov(),
    .dest_file(),
    .use_bank_reg(nw_bank),
    .file_off(nw_off),
    .bit_num(),
    .br_offset()
  );

  lbx_decode u_dec_cur (
    .instr_word(ir_q),
    .is_and(cu_and),
    .is_tog(cu_tog),
    .is_bc(cu_bc),
    .is_bov(cu_bov),
    .dest_file(cu_dest),
    .use_bank_reg(),
    .file_off(),
    .bit_num(cu_bit),
    .br_offset(cu_boff)
  );

  // ==========================================
  // Branch datapath
  wire br_cond;
  wire [PCW-1:0] br_target;

  lbx_branch #(
    .PCW(PCW)
  ) u_branch (
    .pc_cur(pc_q),
    .offset(cu_boff),
    .sel_ovf(cu_bov),
    .carry_flag(carry_flag),
    .overflow_flag(overflow_flag),
    .taken(br_cond),
    .target(br_target)
  );

  // ==========================================
  // Data results
  wire [7:0] and_res;
  wire [7:0] tog_res;
  wire [7:0] bit_mask;
  wire [11:0] bank_addr;

  assign and_res = wreg_value & opnd_q;
  assign bit_mask = 8'h01 << cu_bit;
  assign tog_res = opnd_q ^ bit_mask;
  assign bank_addr = nw_bank ? {bank_select_reg, nw_off} :
    ((nw_off < `LBX_ACC_SPLIT) ? {`LBX_ACC_LO_BANK, nw_off} :
    {`LBX_ACC_HI_BANK, nw_off});

  // ==========================================
  // Quarter sequencing
  always @*
  begin
    q_d = q_q + `LBX_Q_STEP;
    ir_d = ir_q;
    flush_d = flush_q;
    pc_d = pc_q;
    target_d = target_q;
    taken_d = taken_q;
    opnd_d = opnd_q;
    faddr_d = faddr_q;
    frd_d = frd_q;
    fwr_d = fwr_q;
    fdat_d = fdat_q;
    wwr_d = wwr_q;
    wdat_d = wdat_q;
    flg_d = flg_q;
    neg_d = neg_q;
    zero_d = zero_q;
    pcw_d = pcw_q;
    case (q_q)
      `LBX_Q1:
      begin
        // Decode; the flush cycle executes as a no-op
        ir_d = flush_q ? `LBX_NOP_WORD : instr_word;
        faddr_d = bank_addr;
        frd_d = nw_and | nw_tog;
      end
      `LBX_Q2:
      begin
        // Read file operand from file_rd_data
        frd_d = 1'b0;
        opnd_d = file_rd_data;
      end
      `LBX_Q3:
      begin
        // Process and arm Q4 writes
        if (cu_and)
        begin
          fwr_d = cu_dest;
          fdat_d = and_res;
          wwr_d = ~cu_dest;
          wdat_d = and_res;
          flg_d = 1'b1;
          neg_d = and_res[7];
          zero_d = (and_res == 8'h00);
        end
        else if (cu_tog)
        begin
          fwr_d = 1'b1;
          fdat_d = tog_res;
        end
        taken_d = (cu_bc | cu_bov) & br_cond;
        pcw_d = (cu_bc | cu_bov) & br_cond;
        target_d = br_target;
      end
      `LBX_Q4:
      begin
        // Close the instruction cycle
        fwr_d = 1'b0;
        wwr_d = 1'b0;
        flg_d = 1'b0;
        pcw_d = 1'b0;
        taken_d = 1'b0;
        if (taken_q)
        begin
          pc_d = target_q;
        end
        else if (!flush_q)
        begin
          pc_d = pc_q + PC_STEP;
        end
        flush_d = taken_q;
      end
      default:
      begin
        q_d = `LBX_Q1;
      end
    endcase
  end

  // ==========================================
  // Registers
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q_q <= `LBX_Q1;
      ir_q <= `LBX_NOP_WORD;
      flush_q <= 1'b0;
      pc_q <= PC_RESET;
      target_q <= PC_RESET;
      taken_q <= 1'b0;
      opnd_q <= `LBX_BYTE_RESET;
      faddr_q <= `LBX_ADDR_RESET;
      frd_q <= 1'b0;
      fwr_q <= 1'b0;
      fdat_q <= `LBX_BYTE_RESET;
      wwr_q <= 1'b0;
      wdat_q <= `LBX_BYTE_RESET;
      flg_q <= 1'b0;
      neg_q <= 1'b0;
      zero_q <= 1'b0;
      pcw_q <= 1'b0;
    end
    else if (clk_en)
    begin
      q_q <= q_d;
      ir_q <= ir_d;
      flush_q <= flush_d;
      pc_q <= pc_d;
      target_q <= target_d;
      taken_q <= taken_d;
      opnd_q <= opnd_d;
      faddr_q <= faddr_d;
      frd_q <= frd_d;
      fwr_q <= fwr_d;
      fdat_q <= fdat_d;
      wwr_q <= wwr_d;
      wdat_q <= wdat_d;
      flg_q <= flg_d;
      neg_q <= neg_d;
      zero_q <= zero_d;
      pcw_q <= pcw_d;
    end
  end

  // ==========================================
  // Outputs
  assign quarter = q_q;
  assign program_counter = pc_q;
  assign file_addr = faddr_q;
  assign file_rd_en = frd_q;
  assign file_wr_en = fwr_q;
  assign file_wr_data = fdat_q;
  assign wreg_wr_en = wwr_q;
  assign wreg_wr_data = wdat_q;
  assign flag_wr_en = flg_q;
  assign neg_flag = neg_q;
  assign zero_flag = zero_q;
  assign pc_wr_en = pcw_q;
  assign nop_cycle = flush_q;
endmodule // lbx_exec
`default_nettype wire

// *** tb/lbx_exec_props.sv ***
// Assertion checker for the logic and branch execution block
`default_nettype none
module lbx_exec_props #(
  parameter PCW = 21
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  input wire [1:0] quarter,
  input wire [PCW-1:0] program_counter,
  input wire file_rd_en,
  input wire file_wr_en,
  input wire [7:0] file_wr_data,
  input wire wreg_wr_en,
  input wire [7:0] wreg_wr_data,
  input wire flag_wr_en,
  input wire neg_flag,
  input wire zero_flag,
  input wire pc_wr_en,
  input wire nop_cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire [7:0] res = wreg_wr_en ? wreg_wr_data : file_wr_data;
  property p_rd; file_rd_en |-> quarter == 2'h1; endproperty
  a_rd: assert property (p_rd) else $error("read strobe outside Q2");
  property p_wr; (file_wr_en || wreg_wr_en) |-> quarter == 2'h3 && !(file_wr_en && wreg_wr_en); endproperty
  a_wr: assert property (p_wr) else $error("bad write strobe");
  property p_pcq; pc_wr_en |-> quarter == 2'h3 && !nop_cycle; endproperty
  a_pcq: assert property (p_pcq) else $error("counter write outside Q4");
  property p_qtr; (reset_n && clk_en) |=> quarter == $past(quarter) + 2'h1; endproperty
  a_qtr: assert property (p_qtr) else $error("quarter did not step");
  property p_frz; (reset_n && !clk_en) |=> $stable(quarter) && $stable(program_counter); endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  property p_nop; (pc_wr_en && clk_en) |=> nop_cycle [*4]; endproperty
  a_nop: assert property (p_nop) else $error("no idle cycle after branch");
  property p_quiet; nop_cycle |-> !(file_rd_en || file_wr_en || wreg_wr_en || flag_wr_en); endproperty
  a_quiet: assert property (p_quiet) else $error("activity in idle cycle");
  property p_step; (clk_en && quarter == 2'h3 && !pc_wr_en && !nop_cycle) |=> program_counter == $past(program_counter) + 2; endproperty
  a_step: assert property (p_step) else $error("counter did not step by two");
  property p_flag; flag_wr_en |-> neg_flag == res[7] && zero_flag == (res == 8'h00); endproperty
  a_flag: assert property (p_flag) else $error("flags disagree with result");
endmodule // lbx_exec_props
bind lbx_exec lbx_exec_props #(.PCW(PCW)) u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .clk_en(clk_en), .quarter(quarter), .program_counter(program_counter),
  .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
  .wreg_wr_en(wreg_wr_en), .wreg_wr_data(wreg_wr_data), .flag_wr_en(flag_wr_en),
  .neg_flag(neg_flag), .zero_flag(zero_flag), .pc_wr_en(pc_wr_en), .nop_cycle(nop_cycle));
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the logic and branch execution block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, clk_en, carry_flag, overflow_flag;
  logic [15:0] instr_word;
  logic [7:0] wreg_value, file_rd_data, file_wr_data, wreg_wr_data;
  logic [3:0] bank_select_reg;
  logic [1:0] quarter;
  logic [20:0] program_counter, exp_pc;
  logic [11:0] file_addr;
  logic file_rd_en, file_wr_en, wreg_wr_en, flag_wr_en, neg_flag, zero_flag, pc_wr_en, nop_cycle;
  int bad_count, compares;
  lbx_exec #(.PCW(21)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .instr_word(instr_word), .wreg_value(wreg_value), .bank_select_reg(bank_select_reg),
    .carry_flag(carry_flag), .overflow_flag(overflow_flag), .file_rd_data(file_rd_data),
    .quarter(quarter), .program_counter(program_counter), .file_addr(file_addr),
    .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
    .wreg_wr_en(wreg_wr_en), .wreg_wr_data(wreg_wr_data), .flag_wr_en(flag_wr_en),
    .neg_flag(neg_flag), .zero_flag(zero_flag), .pc_wr_en(pc_wr_en), .nop_cycle(nop_cycle));
  // ==========================================
  // Clock and helpers
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One instruction cycle, plus the flush cycle after a taken branch, entered at the edge that starts Q1
  task automatic exec(input logic [15:0] iw, input logic [7:0] w, input logic [7:0] rd,
    input logic [3:0] bs, input logic c, input logic v);
    logic an, tg, tk;
    logic [7:0] r;
    an = iw[15:10] == 6'h05;
    tg = iw[15:12] == 4'h7;
    tk = iw[15:8] == 8'he2 ? c : (iw[15:8] == 8'he4 ? v : 1'b0);
    r = an ? (w & rd) : (rd ^ (8'h01 << iw[11:9]));
    instr_word <= iw;
    wreg_value <= w;
    file_rd_data <= rd;
    bank_select_reg <= bs;
    carry_flag <= c;
    overflow_flag <= v;
    @(posedge sys_clk);
    #1;
    chk("quarter", quarter, 2'h1);
    chk("pc", program_counter, exp_pc);
    chk("rd_en", file_rd_en, an | tg);
    if (an | tg)
      chk("addr", file_addr, {iw[8] ? bs : (iw[7] ? 4'hf : 4'h0), iw[7:0]});
    repeat (2) @(posedge sys_clk);
    #1;
    chk("file_wr", file_wr_en, tg | (an & iw[9]));
    chk("wreg_wr", wreg_wr_en, an & !iw[9]);
    chk("flag_wr", flag_wr_en, an);
    if (an | tg)
      chk("data", (an & !iw[9]) ? wreg_wr_data : file_wr_data, r);
    if (an)
      chk("nz", {neg_flag, zero_flag}, {r[7], r == 8'h00});
    chk("pc_wr", pc_wr_en, tk);
    @(posedge sys_clk);
    exp_pc = exp_pc + 21'd2 + (tk ? {{12{iw[7]}}, iw[7:0], 1'b0} : 21'd0);
    if (tk)
    begin
      instr_word <= 16'h1790;
      @(posedge sys_clk);
      #1;
      chk("nop", {nop_cycle, program_counter}, {1'b1, exp_pc});
      repeat (2) @(posedge sys_clk);
      #1;
      chk("quiet", {file_wr_en, wreg_wr_en, pc_wr_en}, 3'h0);
      @(posedge sys_clk);
    end
  endtask
  // ==========================================
  // Tests
  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    instr_word = 16'h0000;
    wreg_value = 8'h00;
    file_rd_data = 8'h00;
    bank_select_reg = 4'h0;
    carry_flag = 1'b0;
    overflow_flag = 1'b0;
    exp_pc = 21'h0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    exec(16'h1412, 8'h17, 8'hc2, 4'h5, 1'b0, 1'b0);
    exec(16'h1790, 8'hf0, 8'h0f, 4'h3, 1'b1, 1'b1);
    exec(16'h14a5, 8'h80, 8'hff, 4'h3, 1'b0, 1'b0);
    exec(16'h16a5, 8'hf3, 8'h9c, 4'h7, 1'b1, 1'b0);
    for (int b = 0; b < 8; b++)
      exec({4'h7, b[2:0], b[0], 5'h10, b[2:0]}, 8'h00, 8'h75, 4'h9, 1'b1, 1'b1);
    exec(16'he27f, 8'h00, 8'h00, 4'h0, 1'b1, 1'b1);
    exec(16'he205, 8'h00, 8'h00, 4'h0, 1'b0, 1'b1);
    exec(16'he480, 8'h00, 8'h00, 4'h0, 1'b0, 1'b1);
    exec(16'he47f, 8'h00, 8'h00, 4'h0, 1'b1, 1'b0);
    exec(16'he205, 8'h00, 8'h00, 4'h0, 1'b1, 1'b0);
    exec(16'hffff, 8'h00, 8'h00, 4'h0, 1'b1, 1'b1);
    clk_en <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("frozen", {quarter, program_counter}, {2'h0, exp_pc});
    @(posedge sys_clk);
    clk_en <= 1'b1;
    exec(16'h1412, 8'h3c, 8'h0f, 4'h2, 1'b0, 1'b0);
    complete_run();
  end
  initial
  begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
